// *** rtl/cpp_map.vh ***
// constants for the ccd front-end pixel port
`ifndef CPP_MAP_VH
`define CPP_MAP_VH

// pixel word layout
`define CPP_PIXEL_W 12
`define CPP_PIXEL_MSB 11
`define CPP_PIXEL_LSB 0
`define CPP_PIXEL_MAX 12'hfff

// latency pipe stages in output-clock cycles, before the output register
`define CPP_LATENCY 6

// pixel buffer
`define CPP_FIFO_DEPTH 8
`define CPP_FIFO_AW 3

// serial configuration word
`define CPP_CFG_W 16
`define CPP_CFG_RESET 16'h0008
`define CPP_OB_CODE_LSB 0
`define CPP_OB_CODE_W 5

// black clamp level = base + step * code
`define CPP_OB_BASE 12'h040
`define CPP_OB_STEP_SHIFT 3

// loop offset range
`define CPP_OFS_W 13

// clock and far-side timing figures
`define CPP_SYS_CLK_PERIOD_PS 25000
`define CPP_PIXEL_PERIOD_MIN_PS 27700
`define CPP_REF_TO_LEVEL_MIN_PS 5000
`define CPP_LEVEL_TO_REF_MIN_PS 5200
`define CPP_PIXEL_PERIOD_MIN_CYC 2

`endif

// *** rtl/cpp_fifo.v ***
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cpp_fifo #(
    parameter W = 12,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    // honest flags straight from the occupancy count
    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointers and count; depth must be a power of two
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push & ~pop)
                count_r <= count_r + 1'b1;
            else if (pop & ~push)
                count_r <= count_r - 1'b1;
        end
    end

    // storage, no reset needed on the data
    always @(posedge sys_clk) begin
        if (push)
            mem_r[wr_ptr_r] <= in_data;
    end
endmodule
`default_nettype wire

// *** rtl/cpp_pixel_port.v ***
// pixel timing, correlated sampling, clamps, serial config and output port
// Operation
// [R1] each pixel leaves as a 12-bit word with bit 11 the msb and bit 0 the lsb.
// [R2] the output word register changes only on a rising edge of the output word clock.
// [R3] the reference level is captured on each rising edge of the reference sample strobe.
// [R4] the data level is captured on each rising edge of the level sample strobe.
// [R5] the generator leaves at least 5.0 ns from reference strobe end to level strobe start.
// [R6] the generator leaves at least 5.2 ns from level strobe end to next reference strobe.
// [R7] no output clock rise from 9 ns before to 13 ns after a reference strobe rise.
// [R8] no output clock rise from 8 ns before up to a level strobe rise.
// [R9] serial bits shift in on the serial clock and the load strobe latches the word.
// [R10] the generator keeps the pixel period at 27.7 ns or longer.
// [R11] each pixel word appears six output clock cycles after its sampling strobes; the code takes seven, six pipe stages plus the output register.
// [R12] the input clamp acts only while dummy clamp and reference strobes are both high.
// [R13] while the black clamp strobe is high the black offset loop calibrates.
`timescale 1ns/1ps
`default_nettype none
`include "cpp_map.vh"
module cpp_pixel_port #(
    parameter PIXEL_W = `CPP_PIXEL_W,
    parameter LATENCY = `CPP_LATENCY,
    parameter FIFO_DEPTH = `CPP_FIFO_DEPTH,
    parameter FIFO_AW = `CPP_FIFO_AW,
    parameter CFG_W = `CPP_CFG_W
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // sensor level, digitised stand-in for the analog input
    input wire [PIXEL_W-1:0] sensor_level,
    // timing generator strobes
    input wire reference_sample_strobe,
    input wire level_sample_strobe,
    input wire dummy_pixel_clamp_strobe,
    input wire black_pixel_clamp_strobe,
    input wire output_word_clock,
    // serial configuration
    input wire config_serial_clk,
    input wire config_serial_in,
    input wire config_load_strobe,
    // pixel output
    output wire [PIXEL_W-1:0] pixel_out,
    output wire pixel_out_msb,
    output wire pixel_out_lsb,
    output wire pixel_out_valid,
    // status
    output wire input_clamp_active,
    output wire black_cal_active,
    output wire pixel_overflow,
    output wire [CFG_W-1:0] config_word
);
    localparam OFS_W = `CPP_OFS_W;
    // sampling states
    localparam S_WAIT_REF = 2'h0;
    localparam S_WAIT_LEVEL = 2'h1;
    localparam S_PUSH = 2'h2;

    reg ref_d_r, lvl_d_r, oclk_d_r, sclk_d_r, load_d_r;
    reg [1:0] state_r, state_nxt;
    reg [PIXEL_W-1:0] ref_level_r;
    reg [PIXEL_W-1:0] cds_word_r;
    reg cds_clamped_r;
    reg [OFS_W-1:0] black_ofs_r;
    reg [CFG_W-1:0] shift_r;
    reg [CFG_W-1:0] cfg_r;
    reg [PIXEL_W-1:0] out_word_r;
    reg out_valid_r;
    reg overflow_r;
    wire ref_rise, lvl_rise, oclk_rise, sclk_rise, load_rise;
    wire clamp_now;
    wire [PIXEL_W:0] cds_diff;
    wire [OFS_W:0] corrected;
    wire [PIXEL_W-1:0] pixel_word;
    wire [PIXEL_W-1:0] black_target;
    wire fifo_in_valid, fifo_in_ready, fifo_out_valid;
    wire [PIXEL_W-1:0] fifo_out_data;

    // edge detects; inputs arrive synchronous to sys_clk
    assign ref_rise = reference_sample_strobe & ~ref_d_r;
    assign lvl_rise = level_sample_strobe & ~lvl_d_r;
    assign oclk_rise = output_word_clock & ~oclk_d_r;
    assign sclk_rise = config_serial_clk & ~sclk_d_r;
    assign load_rise = config_load_strobe & ~load_d_r;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_d_r <= 1'b0;
            lvl_d_r <= 1'b0;
            oclk_d_r <= 1'b0;
            sclk_d_r <= 1'b0;
            load_d_r <= 1'b0;
        end else begin
            ref_d_r <= reference_sample_strobe;
            lvl_d_r <= level_sample_strobe;
            oclk_d_r <= output_word_clock;
            sclk_d_r <= config_serial_clk;
            load_d_r <= config_load_strobe;
        end
    end

    // [R12] clamp gate needs both strobes
    assign clamp_now = dummy_pixel_clamp_strobe & reference_sample_strobe;
    assign input_clamp_active = clamp_now;
    assign black_cal_active = black_pixel_clamp_strobe;

    // [R9] shift on serial clock, latch on load strobe
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_r <= {CFG_W{1'b0}};
            cfg_r <= `CPP_CFG_RESET;
        end else begin
            if (sclk_rise)
                shift_r <= {shift_r[CFG_W-2:0], config_serial_in};
            if (load_rise)
                cfg_r <= shift_r;
        end
    end
    assign config_word = cfg_r;

    // black clamp level from the configured code
    assign black_target = `CPP_OB_BASE
        + ({{(PIXEL_W-`CPP_OB_CODE_W){1'b0}},
            cfg_r[`CPP_OB_CODE_LSB +: `CPP_OB_CODE_W]} << `CPP_OB_STEP_SHIFT);

    // sampling sequence: reference then level then push
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_WAIT_REF: begin
                if (ref_rise)
                    state_nxt = S_WAIT_LEVEL;
            end
            S_WAIT_LEVEL: begin
                if (lvl_rise)
                    state_nxt = S_PUSH;
            end
            S_PUSH: begin
                // a full buffer drops the pixel rather than stall the sensor
                state_nxt = S_WAIT_REF;
            end
            default: state_nxt = S_WAIT_REF;
        endcase
    end

    // difference of the two samples, floored at zero
    assign cds_diff = {1'b0, sensor_level} - {1'b0, ref_level_r};

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= S_WAIT_REF;
            ref_level_r <= {PIXEL_W{1'b0}};
            cds_word_r <= {PIXEL_W{1'b0}};
            cds_clamped_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // [R3] reference capture
            if (state_r == S_WAIT_REF && ref_rise) begin
                ref_level_r <= sensor_level;
                cds_clamped_r <= clamp_now;
            end
            // [R4] level capture
            if (state_r == S_WAIT_LEVEL && lvl_rise)
                cds_word_r <= cds_diff[PIXEL_W] ? {PIXEL_W{1'b0}} : cds_diff[PIXEL_W-1:0];
        end
    end

    // offset correction, saturated to the word range
    assign corrected = {{(OFS_W-PIXEL_W+1){1'b0}}, cds_word_r}
        + {black_ofs_r[OFS_W-1], black_ofs_r};
    assign pixel_word = corrected[OFS_W] ? {PIXEL_W{1'b0}} :
        (|corrected[OFS_W-1:PIXEL_W]) ? `CPP_PIXEL_MAX : corrected[PIXEL_W-1:0];

    // [R13] one offset step per pixel during black pixels
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            black_ofs_r <= {OFS_W{1'b0}};
        end else if (state_r == S_PUSH && black_pixel_clamp_strobe) begin
            if (pixel_word < black_target)
                black_ofs_r <= black_ofs_r + 1'b1;
            else if (pixel_word > black_target)
                black_ofs_r <= black_ofs_r - 1'b1;
        end
    end

    // clamped reference pixels leave as zero
    assign fifo_in_valid = (state_r == S_PUSH);

    cpp_fifo #(
        .W(PIXEL_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(cds_clamped_r ? {PIXEL_W{1'b0}} : pixel_word),
        .out_valid(fifo_out_valid),
        .out_ready(oclk_rise),
        .out_data(fifo_out_data)
    );

    // sticky overflow: a push refused by a full buffer
    always @(posedge sys_clk or posedge rst) begin
        if (rst)
            overflow_r <= 1'b0;
        else if (fifo_in_valid & ~fifo_in_ready)
            overflow_r <= 1'b1;
    end
    assign pixel_overflow = overflow_r;

    // [R11] latency pipe advances once per output clock
    genvar gi;
    generate
        for (gi = 0; gi < LATENCY; gi = gi + 1) begin : g_pipe
            reg [PIXEL_W-1:0] data_r;
            reg valid_r;
            wire [PIXEL_W-1:0] data_in;
            wire valid_in;
            // per-stage registers keep one driver each
            if (gi == 0) begin : g_head
                assign data_in = fifo_out_data;
                assign valid_in = fifo_out_valid;
            end else begin : g_link
                assign data_in = g_pipe[gi-1].data_r;
                assign valid_in = g_pipe[gi-1].valid_r;
            end
            // stage shifts on each output clock
            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    data_r <= {PIXEL_W{1'b0}};
                    valid_r <= 1'b0;
                end else if (oclk_rise) begin
                    data_r <= data_in;
                    valid_r <= valid_in;
                end
            end
        end
    endgenerate

    // [R2] output register on the output clock edge
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_word_r <= {PIXEL_W{1'b0}};
            out_valid_r <= 1'b0;
        end else if (oclk_rise) begin
            out_word_r <= g_pipe[LATENCY-1].data_r;
            out_valid_r <= g_pipe[LATENCY-1].valid_r;
        end
    end

    // [R1] bit 11 msb, bit 0 lsb
    assign pixel_out = out_word_r;
    assign pixel_out_msb = out_word_r[`CPP_PIXEL_MSB];
    assign pixel_out_lsb = out_word_r[`CPP_PIXEL_LSB];
    assign pixel_out_valid = out_valid_r;
endmodule
`default_nettype wire

// *** testbench/cpp_props.sv ***
// checker watching the pixel port outputs
`timescale 1ns/1ps
`default_nettype none
module cpp_props #(parameter PIXEL_W = 12, parameter CFG_W = 16) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // strobes
    input wire logic reference_sample_strobe,
    input wire logic level_sample_strobe,
    input wire logic dummy_pixel_clamp_strobe,
    input wire logic black_pixel_clamp_strobe,
    input wire logic output_word_clock,
    input wire logic config_load_strobe,
    // outputs
    input wire logic [PIXEL_W-1:0] pixel_out,
    input wire logic pixel_out_msb,
    input wire logic pixel_out_lsb,
    input wire logic pixel_out_valid,
    input wire logic input_clamp_active,
    input wire logic black_cal_active,
    input wire logic pixel_overflow,
    input wire logic [CFG_W-1:0] config_word
);
    // one domain, so one default clock and reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_MSB: assert property (pixel_out_msb == pixel_out[PIXEL_W-1])
        else $error("msb pin differs from word");
    AST_LSB: assert property (pixel_out_lsb == pixel_out[0])
        else $error("lsb pin differs from word");
    AST_WORD: assert property (!$rose(output_word_clock) |=> $stable(pixel_out))
        else $error("word moved without output clock");
    AST_VALID: assert property (!$rose(output_word_clock) |=> $stable(pixel_out_valid))
        else $error("valid moved without output clock");
    AST_CLAMP: assert property (input_clamp_active ==
        (dummy_pixel_clamp_strobe && reference_sample_strobe))
        else $error("clamp flag wrong");
    AST_BLACK: assert property (black_cal_active == black_pixel_clamp_strobe)
        else $error("black loop flag wrong");
    AST_CFG: assert property (!$rose(config_load_strobe) |=> $stable(config_word))
        else $error("config moved without load");
    AST_OVF: assert property ($rose(pixel_overflow) |-> $past(level_sample_strobe, 2))
        else $error("overflow without a level capture");
    AST_STICKY: assert property (pixel_overflow |=> pixel_overflow)
        else $error("overflow flag cleared");
    // main scenarios reached
    cover property ($rose(pixel_out_valid));
    cover property ($rose(pixel_overflow));
    cover property (input_clamp_active);
    cover property ($rose(config_load_strobe));
endmodule
`default_nettype wire

// *** testbench/cpp_tgen.sv ***
// timing generator model: pixel strobes, sensor level, output clock
`timescale 1ns/1ps
`default_nettype none
module cpp_tgen (
    // clock
    input wire logic sys_clk,
    // strobes and level
    output logic [11:0] sensor_level,
    output logic reference_sample_strobe,
    output logic level_sample_strobe,
    output logic dummy_pixel_clamp_strobe,
    output logic output_word_clock
);
    // idle state
    initial begin
        sensor_level = 12'h000;
        reference_sample_strobe = 1'b0;
        level_sample_strobe = 1'b0;
        dummy_pixel_clamp_strobe = 1'b0;
        output_word_clock = 1'b0;
    end
    task pixel(input logic [11:0] r, input logic [11:0] l, input logic dm);
        begin
            @(negedge sys_clk);
            sensor_level = r;
            dummy_pixel_clamp_strobe = dm;
            reference_sample_strobe = 1'b1;
            @(negedge sys_clk);
            reference_sample_strobe = 1'b0;
            dummy_pixel_clamp_strobe = 1'b0;
            @(negedge sys_clk);
            sensor_level = l;
            level_sample_strobe = 1'b1;
            @(negedge sys_clk);
            level_sample_strobe = 1'b0;
            sensor_level = ~l; // held level gone, not left stale
            @(negedge sys_clk);
        end
    endtask
    task oclk(input int n);
        begin
            repeat (n) begin
                @(negedge sys_clk);
                output_word_clock = ~output_word_clock;
                @(negedge sys_clk);
                output_word_clock = ~output_word_clock;
            end
        end
    endtask
endmodule
`default_nettype wire

// *** testbench/cpp_pixel_port_tb.sv ***
// self-checking bench for the pixel port
`timescale 1ns/1ps
`default_nettype none
module cpp_pixel_port_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic black = 1'b0;
    logic sclk = 1'b0;
    logic sin = 1'b0;
    logic load = 1'b0;
    logic [11:0] lvl;
    logic rs, ls, ds, oc, msb, lsb, valid, clamp, bcal, ovf;
    logic [11:0] pix;
    logic [15:0] cfg;
    int errors = 0;
    int n_compared = 0;
    cpp_tgen i_cpp_tgen (.sys_clk(sys_clk), .sensor_level(lvl), .reference_sample_strobe(rs),
        .level_sample_strobe(ls), .dummy_pixel_clamp_strobe(ds), .output_word_clock(oc));
    cpp_pixel_port i_cpp_pixel_port (.sys_clk(sys_clk), .rst(rst), .sensor_level(lvl),
        .reference_sample_strobe(rs), .level_sample_strobe(ls), .dummy_pixel_clamp_strobe(ds),
        .black_pixel_clamp_strobe(black), .output_word_clock(oc), .config_serial_clk(sclk),
        .config_serial_in(sin), .config_load_strobe(load), .pixel_out(pix),
        .pixel_out_msb(msb), .pixel_out_lsb(lsb), .pixel_out_valid(valid),
        .input_clamp_active(clamp), .black_cal_active(bcal), .pixel_overflow(ovf),
        .config_word(cfg));
    // 40 mhz clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            $display("compared %0d mismatches %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task t_reset;
        begin
            check("reset", {2'h0, ovf, valid, pix}, 16'h0000); // cleared word
            check("cfg_reset", cfg, 16'h0008); // default word
            $display("test reset done");
        end
    endtask
    // two pixels, second floored at zero
    task t_order;
        begin
            i_cpp_tgen.pixel(12'h001, 12'hfff, 1'b0);
            i_cpp_tgen.pixel(12'h300, 12'h200, 1'b0);
            i_cpp_tgen.oclk(6);
            check("early", {15'h0, valid}, 16'h0000); // not yet out
            i_cpp_tgen.oclk(1);
            check("word", {3'h0, valid, pix}, 16'h1ffe); // cds word
            check("pins", {14'h0, msb, lsb}, 16'h0002); // bit order
            i_cpp_tgen.oclk(1);
            check("floor", {3'h0, valid, pix}, 16'h1000); // floored
            i_cpp_tgen.oclk(1);
            check("empty", {15'h0, valid}, 16'h0000); // drained
            $display("test order done");
        end
    endtask
    task t_clamp;
        begin
            fork
                i_cpp_tgen.pixel(12'h010, 12'h500, 1'b1);
                begin
                    // look mid-cycle, clear of the strobe's falling change
                    @(negedge sys_clk);
                    @(posedge sys_clk);
                    check("clamp_on", {15'h0, clamp}, 16'h0001); // both high
                end
            join
            i_cpp_tgen.oclk(7);
            check("clamped", {3'h0, valid, pix}, 16'h1000); // zero word
            $display("test clamp done");
        end
    endtask
    // msb first, load rise latches
    task t_config;
        begin
            for (int i = 15; i >= 0; i--) begin
                @(negedge sys_clk);
                sin = 1'(16'h1234 >> i);
                sclk = ~sclk;
                @(negedge sys_clk);
                sclk = ~sclk;
            end
            check("cfg_hold", cfg, 16'h0008); // no load yet
            load = ~load;
            @(negedge sys_clk);
            load = ~load;
            @(negedge sys_clk);
            check("cfg_load", cfg, 16'h1234); // latched word
            $display("test config done");
        end
    endtask
    // fill past eight words, then drain in order
    task t_fill;
        begin
            for (int i = 1; i <= 9; i++) begin
                i_cpp_tgen.pixel(12'h000, 12'(i), 1'b0);
                check("ovf", {15'h0, ovf}, 16'(i == 9)); // dropped ninth
            end
            i_cpp_tgen.oclk(6);
            for (int i = 1; i <= 9; i++) begin
                i_cpp_tgen.oclk(1);
                check("drain_valid", {15'h0, valid}, 16'(i < 9)); // eight valid, ninth slot empty
                // data after the last word is stale buffer content
                if (i < 9) check("drain", {4'h0, pix}, 16'(i)); // order
            end
            $display("test fill done");
        end
    endtask
    task t_black;
        begin
            @(negedge sys_clk);
            black = ~black;
            i_cpp_tgen.pixel(12'h000, 12'h000, 1'b0);
            check("black_on", {15'h0, bcal}, 16'h0001); // loop running
            black = ~black;
            // black pixel below target steps the offset up by one
            i_cpp_tgen.pixel(12'h000, 12'h010, 1'b0);
            i_cpp_tgen.oclk(7);
            check("black_px", {15'h0, valid}, 16'h0001); // pixel kept
            check("black_word", {3'h0, valid, pix}, 16'h1000); // raw black pixel
            i_cpp_tgen.oclk(1);
            check("black_step", {3'h0, valid, pix}, 16'h1011); // offset stepped
            $display("test black done");
        end
    endtask
    // sequence and hang guard
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        t_reset;
        t_order;
        t_clamp;
        t_config;
        t_fill;
        t_black;
        summarize;
    end
    initial begin
        #1000000;
        errors = errors + 1;
        summarize;
    end
endmodule
bind cpp_pixel_port cpp_props #(.PIXEL_W(PIXEL_W), .CFG_W(CFG_W)) i_cpp_props (
    .sys_clk(sys_clk), .rst(rst), .reference_sample_strobe(reference_sample_strobe),
    .level_sample_strobe(level_sample_strobe), .dummy_pixel_clamp_strobe(dummy_pixel_clamp_strobe),
    .black_pixel_clamp_strobe(black_pixel_clamp_strobe), .output_word_clock(output_word_clock),
    .config_load_strobe(config_load_strobe), .pixel_out(pixel_out), .pixel_out_msb(pixel_out_msb),
    .pixel_out_lsb(pixel_out_lsb), .pixel_out_valid(pixel_out_valid),
    .input_clamp_active(input_clamp_active), .black_cal_active(black_cal_active),
    .pixel_overflow(pixel_overflow), .config_word(config_word));
`default_nettype wire
